// ---- dv/tsw_periph_model.sv ----
// memory and peripheral side: answers vector fetches, records stack pushes
// assumes one request at a time from the unit; waitCyc slows every answer
`timescale 1ns/1ps
module tsw_periph_model (
	input logic clk,
	input logic sys_rst,
	input logic [3:0] waitCyc,
	input logic [15:0] newPc,
	input logic [15:0] newPs,
	input tsw_pkg::tsw_fetch_t vecFetch,
	output logic vecAck,
	output logic [15:0] vecRdata,
	input tsw_pkg::tsw_push_t stackPush,
	output logic pushAck,
	output logic [15:0] pushedPs,
	output logic [15:0] pushedPc,
	output logic pushUser
);
	logic [3:0] cnt_q;
	logic pushN_q;
	always_ff @(posedge clk) begin
		vecAck <= 1'b0;
		pushAck <= 1'b0;
		// released data bus does not hold its last word
		vecRdata <= ~vecRdata;
		if (sys_rst) begin
			cnt_q <= 4'h0;
			pushN_q <= 1'b0;
			vecRdata <= 16'h0000;
		end else if ((vecFetch.valid || stackPush.valid) && !vecAck && !pushAck) begin
			if (cnt_q < waitCyc) begin
				cnt_q <= cnt_q + 4'h1;
			end else begin
				cnt_q <= 4'h0;
				if (vecFetch.valid) begin
					vecAck <= 1'b1;
					vecRdata <= vecFetch.addr[1] ? newPs : newPc;
				end else begin
					pushAck <= 1'b1;
					pushN_q <= ~pushN_q;
					pushUser <= stackPush.userStack;
					if (pushN_q) pushedPc <= stackPush.data;
					else pushedPs <= stackPush.data;
				end
			end
		end
	end
endmodule

// ---- dv/tsw_trap_status_checker.sv ----
// port assertions for the status word unit
// assumes one clock domain; bound onto tsw_trap_status below
`timescale 1ns/1ps
module tsw_trap_status_checker (
	input logic clk,
	input logic sys_rst,
	input logic [3:0] regAddr,
	input logic regWr,
	input logic regRd,
	input logic [15:0] regRdata,
	input logic pswUserMapped,
	input logic instrEnd,
	input tsw_pkg::tsw_instr_t instrInfo,
	input logic mmuEnabled,
	input logic memIsMos,
	input logic trapReq,
	input logic returnReq,
	input logic [15:0] stackedPs,
	input logic [2:0] intLevel,
	input logic intAck,
	input logic nprReq,
	input logic nprGrant,
	input tsw_pkg::tsw_fetch_t vecFetch,
	input logic vecAck,
	input logic [15:0] vecRdata,
	input tsw_pkg::tsw_push_t stackPush,
	input logic pushAck,
	input logic [15:0] psw,
	input logic trapBusy,
	input logic [15:0] instrTimeNs
);
	logic fPh_q;
	logic pPh_q;
	logic [15:0] oldPs_q;
	logic [15:0] expT_q;
	function automatic logic [15:0] expT(tsw_pkg::tsw_instr_t i, logic m, logic s);
		logic [15:0] t;
		case (i.cls)
			tsw_pkg::TSW_CLS_DOUBLE: t = i.srcNs + i.dstNs + i.efNs;
			tsw_pkg::TSW_CLS_SINGLE: t = i.dstNs + i.efNs;
			tsw_pkg::TSW_CLS_EF_ONLY: t = i.efNs;
			default: t = s ? (i.taken ? 16'h0906 : 16'h06e0) : (i.taken ? 16'h0884 : 16'h065e);
		endcase
		t = t + 16'(i.extraSteps) * 16'h00c8;
		if (m) t = t + 16'h0078 * ((i.cls == tsw_pkg::TSW_CLS_BRANCH) ? 16'h0001 : 16'(i.memCycles));
		return t;
	endfunction
	// second vector word and first push are told apart by these phases
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fPh_q <= 1'b0;
			pPh_q <= 1'b0;
		end else begin
			if (vecFetch.valid && vecAck) fPh_q <= ~fPh_q;
			if (stackPush.valid && pushAck) pPh_q <= ~pPh_q;
		end
	end
	always_ff @(posedge clk) begin
		if (vecFetch.valid && vecAck && fPh_q) oldPs_q <= psw;
		if (instrEnd) expT_q <= expT(instrInfo, mmuEnabled, memIsMos);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_kernelVec; vecFetch.valid |-> vecFetch.kernelSpace; endproperty
	a_kernelVec: assert property (p_kernelVec) else $error("vector fetch not in kernel space");
	property p_stackSel; stackPush.valid |-> stackPush.userStack == (psw[15:14] == 2'h3); endproperty
	a_stackSel: assert property (p_stackSel) else $error("push to wrong stack");
	property p_retUser; returnReq && !trapBusy && !trapReq && !instrEnd && psw[15:14] == 2'h3
		|=> psw == {$past(psw[15:5]), $past(stackedPs[4:0])}; endproperty
	a_retUser: assert property (p_retUser) else $error("user return status wrong");
	property p_traceWr; regWr && regAddr == 4'h0 && !trapBusy && !trapReq && !returnReq && !instrEnd
		|=> psw[4] == $past(psw[4]); endproperty
	a_traceWr: assert property (p_traceWr) else $error("trace bit written");
	property p_vecLoad; vecFetch.valid && vecAck && fPh_q
		|=> {psw[15:14], psw[11:0]} == {$past(vecRdata[15:14]), $past(vecRdata[11:0])}; endproperty
	a_vecLoad: assert property (p_vecLoad) else $error("entry status not from vector");
	property p_prevCopy; vecFetch.valid && vecAck && fPh_q |=> psw[13:12] == $past(psw[15:14]); endproperty
	a_prevCopy: assert property (p_prevCopy) else $error("previous mode not copied");
	property p_regRead; regRd && regAddr == 4'h0 |=> regRdata ==
		(($past(psw[15:14]) == 2'h3 && !$past(pswUserMapped)) ? 16'h0000 : $past(psw)); endproperty
	a_regRead: assert property (p_regRead) else $error("status read wrong");
	property p_time; instrEnd |=> instrTimeNs == expT_q; endproperty
	a_time: assert property (p_time) else $error("instruction time wrong");
	property p_ackEnd; intAck |-> $past(instrEnd) && $past(intLevel) > $past(psw[7:5]); endproperty
	a_ackEnd: assert property (p_ackEnd) else $error("interrupt acknowledged off boundary");
	property p_dma; $rose(nprReq) |-> ##[1:625] (nprGrant || !nprReq); endproperty
	a_dma: assert property (p_dma) else $error("bus grant too late");
	property p_oldPs; stackPush.valid && !pPh_q |-> stackPush.data == oldPs_q; endproperty
	a_oldPs: assert property (p_oldPs) else $error("pushed status not the old one");
endmodule
bind tsw_trap_status tsw_trap_status_checker u_chk (.clk, .sys_rst, .regAddr, .regWr, .regRd,
	.regRdata, .pswUserMapped, .instrEnd, .instrInfo, .mmuEnabled, .memIsMos, .trapReq,
	.returnReq, .stackedPs, .intLevel, .intAck, .nprReq, .nprGrant, .vecFetch, .vecAck,
	.vecRdata, .stackPush, .pushAck, .psw, .trapBusy, .instrTimeNs);

// ---- dv/tsw_trap_status_tb.sv ----
// self-checking bench for the status word unit
// assumes the peripheral model answers fetches and pushes
`timescale 1ns/1ps
module tsw_trap_status_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic pswUserMapped = 1'b0;
	logic instrEnd = 1'b0;
	tsw_pkg::tsw_instr_t instrInfo = '0;
	logic mmuEnabled = 1'b0;
	logic memIsMos = 1'b0;
	logic trapReq = 1'b0;
	logic returnReq = 1'b0;
	logic intReq = 1'b0;
	logic nprReq = 1'b0;
	logic cpuMemBusy = 1'b0;
	logic [2:0] intLevel = 3'h0;
	logic [3:0] waitCyc = 4'h0;
	logic [15:0] trapVector = 16'h0040;
	logic [15:0] intVector = 16'h0060;
	logic [15:0] oldPc = 16'h0000;
	logic [15:0] stackedPs = 16'h0000;
	logic [15:0] newPc = 16'h0000;
	logic [15:0] newPs = 16'h0000;
	logic [15:0] regRdata, handlerPc, psw, instrTimeNs, vecRdata, pushedPs, pushedPc;
	logic intAck, nprGrant, cpuHold, vecAck, pushAck, handlerStart, trapBusy, pushUser;
	tsw_pkg::tsw_fetch_t vecFetch;
	tsw_pkg::tsw_push_t stackPush;
	int num_errors = 0;
	int compares = 0;
	always #2 clk = ~clk;
	tsw_trap_status dut (.clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.pswUserMapped, .instrEnd, .instrInfo, .mmuEnabled, .memIsMos, .trapReq, .trapVector,
		.oldPc, .returnReq, .stackedPs, .intReq, .intLevel, .intVector, .intAck, .nprReq,
		.cpuMemBusy, .nprGrant, .cpuHold, .vecFetch, .vecAck, .vecRdata, .stackPush, .pushAck,
		.handlerStart, .handlerPc, .psw, .trapBusy, .instrTimeNs);
	tsw_periph_model partner (.clk, .sys_rst, .waitCyc, .newPc, .newPs, .vecFetch, .vecAck,
		.vecRdata, .stackPush, .pushAck, .pushedPs, .pushedPc, .pushUser);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	task automatic entry(input logic [15:0] eP, input logic [15:0] oP, input logic [15:0] oC,
		input logic u);
		int n = 0;
		while (handlerStart !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk({15'h0000, handlerStart}, 16'h0001);
		chk(psw, eP);
		chk(handlerPc, newPc);
		chk(pushedPs, oP);
		chk(pushedPc, oC);
		chk({15'h0000, pushUser}, {15'h0000, u});
	endtask
	task automatic tm(input tsw_pkg::tsw_class_t c, input logic [15:0] s, input logic [15:0] d,
		input logic [15:0] f, input logic [2:0] mc, input logic [4:0] st, input logic tk,
		input logic m, input logic [15:0] e);
		@(posedge clk);
		instrInfo <= '{c, s, d, f, mc, st, tk};
		mmuEnabled <= m;
		instrEnd <= 1'b1;
		@(posedge clk);
		instrEnd <= 1'b0;
		#1 chk(instrTimeNs, e);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: run hung, seen %h expected %h", $time, 1'b0, 1'b1);
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(4'h0, 16'h0000);
		wr(4'h0, 16'h00ff);
		rd(4'h0, 16'h00ef);
		rd(4'h9, 16'h0000);
		$display("register test done");
		@(posedge clk);
		waitCyc <= 4'h3;
		newPc <= 16'h1234;
		newPs <= 16'hf0b5;
		oldPc <= 16'h0500;
		trapReq <= 1'b1;
		@(posedge clk);
		trapReq <= 1'b0;
		entry(16'hc0b5, 16'h00ef, 16'h0500, 1'b1);
		$display("trap test done");
		rd(4'h0, 16'h0000);
		wr(4'h0, 16'h0000);
		#1 chk(psw, 16'hc0b5);
		@(posedge clk);
		pswUserMapped <= 1'b1;
		wr(4'h0, 16'hc0a0);
		rd(4'h0, 16'hc0b0);
		@(posedge clk);
		returnReq <= 1'b1;
		stackedPs <= 16'h3f0a;
		@(posedge clk);
		returnReq <= 1'b0;
		#1 chk(psw, 16'hc0aa);
		$display("user mode test done");
		@(posedge clk);
		waitCyc <= 4'h0;
		newPc <= 16'h2000;
		newPs <= 16'h0040;
		oldPc <= 16'h0600;
		intReq <= 1'b1;
		intLevel <= 3'h5;
		tm(tsw_pkg::TSW_CLS_EF_ONLY, 16'h0, 16'h0, 16'h07ee, 3'h1, 5'h0, 1'b0, 1'b0, 16'h07ee);
		chk({15'h0000, intAck}, 16'h0000);
		@(posedge clk);
		intLevel <= 3'h7;
		repeat (3) @(posedge clk);
		#1 chk({15'h0000, intAck}, 16'h0000);
		tm(tsw_pkg::TSW_CLS_EF_ONLY, 16'h0, 16'h0, 16'h07ee, 3'h1, 5'h0, 1'b0, 1'b0, 16'h07ee);
		chk({15'h0000, intAck}, 16'h0001);
		@(posedge clk);
		intReq <= 1'b0;
		entry(16'h3040, 16'hc0aa, 16'h0600, 1'b0);
		$display("interrupt test done");
		tm(tsw_pkg::TSW_CLS_DOUBLE, 16'h046a, 16'h0654, 16'h07ee, 3'h1, 5'h0, 1'b0, 1'b0, 16'h12ac);
		tm(tsw_pkg::TSW_CLS_SINGLE, 16'h046a, 16'h0654, 16'h07ee, 3'h1, 5'h0, 1'b0, 1'b0, 16'h0e42);
		tm(tsw_pkg::TSW_CLS_BRANCH, 16'h0, 16'h0, 16'h0, 3'h1, 5'h0, 1'b1, 1'b0, 16'h0884);
		tm(tsw_pkg::TSW_CLS_BRANCH, 16'h0, 16'h0, 16'h0, 3'h1, 5'h0, 1'b0, 1'b0, 16'h065e);
		tm(tsw_pkg::TSW_CLS_DOUBLE, 16'h046a, 16'h0654, 16'h07ee, 3'h3, 5'h0, 1'b0, 1'b1, 16'h1414);
		tm(tsw_pkg::TSW_CLS_SINGLE, 16'h0, 16'h0, 16'h2274, 3'h1, 5'h3, 1'b0, 1'b0, 16'h24cc);
		@(posedge clk);
		memIsMos <= 1'b1;
		tm(tsw_pkg::TSW_CLS_BRANCH, 16'h0, 16'h0, 16'h0, 3'h1, 5'h0, 1'b1, 1'b0, 16'h0906);
		rd(4'h2, 16'h0010);
		@(posedge clk);
		memIsMos <= 1'b0;
		rd(4'h1, 16'h0906);
		rd(4'h3, 16'h0242);
		$display("timing test done");
		@(posedge clk);
		cpuMemBusy <= 1'b1;
		nprReq <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk({14'h0000, cpuHold, nprGrant}, 16'h0002);
		@(posedge clk);
		cpuMemBusy <= 1'b0;
		@(posedge clk);
		#1 chk({15'h0000, nprGrant}, 16'h0001);
		@(posedge clk);
		nprReq <= 1'b0;
		repeat (2) @(posedge clk);
		cpuMemBusy <= 1'b1;
		nprReq <= 1'b1;
		repeat (625) @(posedge clk);
		#1 chk({15'h0000, nprGrant}, 16'h0001);
		@(posedge clk);
		nprReq <= 1'b0;
		rd(4'h2, 16'h0002);
		wr(4'h2, 16'h0002);
		rd(4'h2, 16'h0000);
		@(posedge clk);
		cpuMemBusy <= 1'b0;
		$display("bus grant test done");
		finish_test();
	end
endmodule

// ---- src/tsw_cfg.svh ----
// constants for the trap status word and timing unit
// assumes a 4 ns processor clock and a 16-bit register port
`ifndef TSW_CFG_SVH
`define TSW_CFG_SVH

`define TSW_CLK_NS 4

// register indices on the local port
`define TSW_ADDR_PSW 4'h0
`define TSW_ADDR_TIME 4'h1
`define TSW_ADDR_STAT 4'h2
`define TSW_ADDR_TIMECYC 4'h3

// status word fields
`define TSW_CC_HI 3
`define TSW_CC_LO 0
`define TSW_TRACE_BIT 4
`define TSW_PRIO_HI 7
`define TSW_PRIO_LO 5
`define TSW_PREV_HI 13
`define TSW_PREV_LO 12
`define TSW_CUR_HI 15
`define TSW_CUR_LO 14
`define TSW_MODE_KERNEL 2'h0
`define TSW_MODE_USER 2'h3
`define TSW_PSW_RESET 16'h0000

// timing model in nanoseconds
`define TSW_MMU_EXTRA_NS 16'h0078
`define TSW_STEP_NS 16'h00c8
`define TSW_TOL_PCT 10
`define TSW_CORE_ACCESS_NS 510
`define TSW_CORE_CYCLE_NS 1000
`define TSW_MOS_ACCESS_NS 635
`define TSW_MOS_CYCLE_NS 775
`define TSW_BR_TAKEN_CORE_NS 16'h0884
`define TSW_BR_NOT_CORE_NS 16'h065e
`define TSW_BR_TAKEN_MOS_NS 16'h0906
`define TSW_BR_NOT_MOS_NS 16'h06e0
`define TSW_BR_MEM_CYCLES 3'h1

// latency bounds: longest times round down to whole cycles
`define TSW_SVC_CORE_NS 7320
`define TSW_SVC_MOS_NS 7700
`define TSW_NPR_MAX_NS 2500
`define TSW_SVC_CORE_CYC (`TSW_SVC_CORE_NS / `TSW_CLK_NS)
`define TSW_SVC_MOS_CYC (`TSW_SVC_MOS_NS / `TSW_CLK_NS)
`define TSW_NPR_MAX_CYC (`TSW_NPR_MAX_NS / `TSW_CLK_NS)
// grant margin so the grant lands inside the bound
`define TSW_NPR_MARGIN 2

`endif

// ---- src/tsw_latency_timer.sv ----
// bound timer: counts cycles from start until stop
// assumes start is a single-cycle pulse from the parent; stop may be a held level (nprTimer stop stays high while no request is pending)
`timescale 1ns/1ps
module tsw_latency_timer (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic stop,
	input wire logic [11:0] limit,
	output logic running,
	output logic expired
);

	logic running_q;
	logic [11:0] count_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			running_q <= 1'b0;
		end else if (start) begin
			running_q <= 1'b1;
		end else if (stop) begin
			running_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || start) begin
			count_q <= 12'h000;
		end else if (running_q && count_q != 12'hfff) begin
			count_q <= count_q + 12'h001;
		end
	end

	assign running = running_q;
	assign expired = running_q && (count_q >= limit);

endmodule

// ---- src/tsw_pkg.sv ----
// types shared by the trap status word unit
// no assumptions beyond the cfg header
package tsw_pkg;

	typedef enum logic [1:0] {
		TSW_CLS_DOUBLE,
		TSW_CLS_SINGLE,
		TSW_CLS_EF_ONLY,
		TSW_CLS_BRANCH
	} tsw_class_t;

	typedef enum {
		TSW_ST_IDLE,
		TSW_ST_VEC_PC,
		TSW_ST_VEC_PS,
		TSW_ST_PUSH_PS,
		TSW_ST_PUSH_PC,
		TSW_ST_HANDLER
	} tsw_state_t;

	// memory read of a vector word
	typedef struct packed {
		logic valid;
		logic kernelSpace;
		logic [15:0] addr;
	} tsw_fetch_t;

	// stack push of one word
	typedef struct packed {
		logic valid;
		logic userStack;
		logic [15:0] data;
	} tsw_push_t;

	// timing description of one retiring instruction
	typedef struct packed {
		tsw_class_t cls;
		logic [15:0] srcNs;
		logic [15:0] dstNs;
		logic [15:0] efNs;
		logic [2:0] memCycles;
		logic [4:0] extraSteps;
		logic taken;
	} tsw_instr_t;

endpackage

// ---- src/tsw_trap_status.sv ----
// status word update on trap, interrupt and return, plus the timing model
// assumes the core pulses events on clk and that memory answers with ack pulses
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "tsw_cfg.svh"

module tsw_trap_status (
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic pswUserMapped,
	// core events
	input wire logic instrEnd,
	input wire tsw_pkg::tsw_instr_t instrInfo,
	input wire logic mmuEnabled,
	input wire logic memIsMos,
	input wire logic trapReq,
	input wire logic [15:0] trapVector,
	input wire logic [15:0] oldPc,
	input wire logic returnReq,
	input wire logic [15:0] stackedPs,
	// peripheral interrupt request
	input wire logic intReq,
	input wire logic [2:0] intLevel,
	input wire logic [15:0] intVector,
	output logic intAck,
	// bus request from a dma device
	input wire logic nprReq,
	input wire logic cpuMemBusy,
	output logic nprGrant,
	output logic cpuHold,
	// vector fetch and stack push
	output tsw_pkg::tsw_fetch_t vecFetch,
	input wire logic vecAck,
	input wire logic [15:0] vecRdata,
	output tsw_pkg::tsw_push_t stackPush,
	input wire logic pushAck,
	// handler start
	output logic handlerStart,
	output logic [15:0] handlerPc,
	output logic [15:0] psw,
	output logic trapBusy,
	output logic [15:0] instrTimeNs
);

	tsw_pkg::tsw_state_t state_q;
	logic [15:0] psw_q;
	logic [15:0] oldPs_q;
	logic [15:0] oldPc_q;
	logic [15:0] vecAddr_q;
	logic [15:0] newPc_q;
	logic [15:0] newPs_q;
	logic startIntr;
	logic startEntry;
	logic userMode;
	logic explicitOk;
	logic pswWrite;
	logic svcRunning;
	logic svcExpired;
	logic svcOverrun_q;
	logic nprOverrun_q;
	logic [11:0] svcLimit;
	logic nprWaiting;
	logic nprExpired;
	logic nprGrant_q;
	logic [15:0] regRdata_q;
	logic [15:0] time_q;
	logic [15:0] timeCyc_q;
	logic [15:0] timeNs;
	logic [15:0] brNs;
	logic [15:0] mmuNs;
	logic [15:0] stepNs;
	logic handlerStart_q;
	logic intAck_q;

	assign userMode = psw_q[`TSW_CUR_HI:`TSW_CUR_LO] == `TSW_MODE_USER;

	assign startIntr = intReq && instrEnd && !trapReq && state_q == tsw_pkg::TSW_ST_IDLE &&
		intLevel > psw_q[`TSW_PRIO_HI:`TSW_PRIO_LO];
	assign startEntry = (trapReq || startIntr) && state_q == tsw_pkg::TSW_ST_IDLE;

	assign explicitOk = !userMode || pswUserMapped;
	assign pswWrite = regWr && regAddr == `TSW_ADDR_PSW && explicitOk;

	// entry sequencer: vector pc, vector status, push status, push pc
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= tsw_pkg::TSW_ST_IDLE;
		end else begin
			case (state_q)
				tsw_pkg::TSW_ST_IDLE: begin
					if (startEntry) begin
						state_q <= tsw_pkg::TSW_ST_VEC_PC;
					end
				end
				tsw_pkg::TSW_ST_VEC_PC: begin
					if (vecAck) begin
						state_q <= tsw_pkg::TSW_ST_VEC_PS;
					end
				end
				tsw_pkg::TSW_ST_VEC_PS: begin
					if (vecAck) begin
						state_q <= tsw_pkg::TSW_ST_PUSH_PS;
					end
				end
				tsw_pkg::TSW_ST_PUSH_PS: begin
					if (pushAck) begin
						state_q <= tsw_pkg::TSW_ST_PUSH_PC;
					end
				end
				tsw_pkg::TSW_ST_PUSH_PC: begin
					if (pushAck) begin
						state_q <= tsw_pkg::TSW_ST_HANDLER;
					end
				end
				tsw_pkg::TSW_ST_HANDLER: begin
					state_q <= tsw_pkg::TSW_ST_IDLE;
				end
				default: begin
					state_q <= tsw_pkg::TSW_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oldPs_q <= 16'h0000;
			oldPc_q <= 16'h0000;
			vecAddr_q <= 16'h0000;
		end else if (startEntry) begin
			oldPs_q <= psw_q;
			oldPc_q <= oldPc;
			vecAddr_q <= trapReq ? trapVector : intVector;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			newPc_q <= 16'h0000;
			newPs_q <= 16'h0000;
		end else if (vecAck && state_q == tsw_pkg::TSW_ST_VEC_PC) begin
			newPc_q <= vecRdata;
		end else if (vecAck && state_q == tsw_pkg::TSW_ST_VEC_PS) begin
			newPs_q <= vecRdata;
		end
	end

	always_comb begin
		vecFetch.valid = !nprGrant_q && (state_q == tsw_pkg::TSW_ST_VEC_PC ||
			state_q == tsw_pkg::TSW_ST_VEC_PS);
		vecFetch.kernelSpace = 1'b1;
		vecFetch.addr = state_q == tsw_pkg::TSW_ST_VEC_PS ? vecAddr_q + 16'h0002 : vecAddr_q;
	end

	always_comb begin
		stackPush.valid = !nprGrant_q && (state_q == tsw_pkg::TSW_ST_PUSH_PS ||
			state_q == tsw_pkg::TSW_ST_PUSH_PC);
		stackPush.userStack = psw_q[`TSW_CUR_HI:`TSW_CUR_LO] == `TSW_MODE_USER;
		stackPush.data = state_q == tsw_pkg::TSW_ST_PUSH_PS ? oldPs_q : oldPc_q;
	end

	// status word update; entry wins over return, return over explicit write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psw_q <= `TSW_PSW_RESET;
		end else if (state_q == tsw_pkg::TSW_ST_VEC_PS && vecAck) begin
			psw_q[`TSW_CC_HI:`TSW_CC_LO] <= vecRdata[`TSW_CC_HI:`TSW_CC_LO];
			psw_q[`TSW_TRACE_BIT] <= vecRdata[`TSW_TRACE_BIT];
			psw_q[`TSW_PRIO_HI:`TSW_PRIO_LO] <= vecRdata[`TSW_PRIO_HI:`TSW_PRIO_LO];
			psw_q[11:8] <= vecRdata[11:8];
			psw_q[`TSW_PREV_HI:`TSW_PREV_LO] <= oldPs_q[`TSW_CUR_HI:`TSW_CUR_LO];
			psw_q[`TSW_CUR_HI:`TSW_CUR_LO] <= vecRdata[`TSW_CUR_HI:`TSW_CUR_LO];
		end else if (returnReq && state_q == tsw_pkg::TSW_ST_IDLE) begin
			if (userMode) begin
				psw_q[`TSW_CC_HI:`TSW_CC_LO] <= stackedPs[`TSW_CC_HI:`TSW_CC_LO];
				psw_q[`TSW_TRACE_BIT] <= stackedPs[`TSW_TRACE_BIT];
			end else begin
				psw_q <= stackedPs;
			end
		end else if (pswWrite) begin
			psw_q <= {regWdata[15:5], psw_q[`TSW_TRACE_BIT], regWdata[3:0]};
		end
	end

	assign svcLimit = memIsMos ? 12'(`TSW_SVC_MOS_CYC) : 12'(`TSW_SVC_CORE_CYC);

	tsw_latency_timer svcTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(startIntr),
		.stop(state_q == tsw_pkg::TSW_ST_HANDLER),
		.limit(svcLimit),
		.running(svcRunning),
		.expired(svcExpired)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			svcOverrun_q <= 1'b0;
		end else if (svcExpired && svcRunning) begin
			svcOverrun_q <= 1'b1;
		end else if (regWr && regAddr == `TSW_ADDR_STAT && regWdata[0]) begin
			svcOverrun_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			intAck_q <= 1'b0;
			handlerStart_q <= 1'b0;
			handlerPc <= 16'h0000;
		end else begin
			intAck_q <= startIntr;
			handlerStart_q <= state_q == tsw_pkg::TSW_ST_PUSH_PC && pushAck;
			if (state_q == tsw_pkg::TSW_ST_PUSH_PC && pushAck) begin
				handlerPc <= newPc_q;
			end
		end
	end

	assign nprWaiting = nprReq && !nprGrant_q;

	tsw_latency_timer nprTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(nprWaiting && !cpuHold),
		// a withdrawn request must not leave the hold standing
		.stop(nprGrant_q || !nprReq),
		.limit(12'(`TSW_NPR_MAX_CYC - `TSW_NPR_MARGIN)),
		.running(cpuHold),
		.expired(nprExpired)
	);

	// grant when bus free or forced
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nprGrant_q <= 1'b0;
		end else if (!nprReq) begin
			nprGrant_q <= 1'b0;
		end else if (!cpuMemBusy || nprExpired) begin
			nprGrant_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nprOverrun_q <= 1'b0;
		end else if (nprExpired && cpuMemBusy && !nprGrant_q) begin
			nprOverrun_q <= 1'b1;
		end else if (regWr && regAddr == `TSW_ADDR_STAT && regWdata[1]) begin
			nprOverrun_q <= 1'b0;
		end
	end

	always_comb begin
		if (memIsMos) begin
			brNs = instrInfo.taken ? `TSW_BR_TAKEN_MOS_NS : `TSW_BR_NOT_MOS_NS;
		end else begin
			brNs = instrInfo.taken ? `TSW_BR_TAKEN_CORE_NS : `TSW_BR_NOT_CORE_NS;
		end
	end

	assign mmuNs = mmuEnabled ? 16'(`TSW_MMU_EXTRA_NS * (instrInfo.cls ==
		tsw_pkg::TSW_CLS_BRANCH ? `TSW_BR_MEM_CYCLES : instrInfo.memCycles)) : 16'h0000;
	assign stepNs = 16'(`TSW_STEP_NS * instrInfo.extraSteps);

	always_comb begin
		case (instrInfo.cls)
			tsw_pkg::TSW_CLS_DOUBLE: begin
				timeNs = instrInfo.srcNs + instrInfo.dstNs + instrInfo.efNs;
			end
			tsw_pkg::TSW_CLS_SINGLE: begin
				timeNs = instrInfo.dstNs + instrInfo.efNs;
			end
			tsw_pkg::TSW_CLS_EF_ONLY: begin
				timeNs = instrInfo.efNs;
			end
			tsw_pkg::TSW_CLS_BRANCH: begin
				timeNs = brNs;
			end
			default: begin
				timeNs = instrInfo.efNs;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			time_q <= 16'h0000;
			timeCyc_q <= 16'h0000;
		end else if (instrEnd) begin
			time_q <= timeNs + mmuNs + stepNs;
			timeCyc_q <= 16'((timeNs + mmuNs + stepNs + 16'h0003) >> 2);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata_q <= 16'h0000;
		end else if (regRd) begin
			case (regAddr)
				`TSW_ADDR_PSW: begin
					regRdata_q <= explicitOk ? psw_q : 16'h0000;
				end
				`TSW_ADDR_TIME: begin
					regRdata_q <= time_q;
				end
				`TSW_ADDR_TIMECYC: begin
					regRdata_q <= timeCyc_q;
				end
				`TSW_ADDR_STAT: begin
					regRdata_q <= {11'h000, memIsMos, userMode, trapBusy, nprOverrun_q,
						svcOverrun_q};
				end
				default: begin
					regRdata_q <= 16'h0000;
				end
			endcase
		end else begin
			regRdata_q <= 16'h0000;
		end
	end

	assign regRdata = regRdata_q;
	assign psw = psw_q;
	assign trapBusy = state_q != tsw_pkg::TSW_ST_IDLE;
	assign intAck = intAck_q;
	assign handlerStart = handlerStart_q;
	assign nprGrant = nprGrant_q;
	assign instrTimeNs = time_q;

endmodule
